// ---- bench/hubctl_host_model.sv ----
`timescale 1ns/10ps
// ----
// host bus controller
// ----
module hubctl_host_model (
	input  wire logic              clk,
	input  wire logic              ack,
	input  wire logic              ack_valid,
	input  wire logic              tx_valid,
	input  wire logic [7:0]        tx_byte,
	input  wire logic              tx_tbit,
	output hubctl_pkg::hubctl_rx_t rx,
	output logic                   tx_taken
);
	initial
	begin
		rx = '0;
		tx_taken = 1'h0;
	end

	// quiet cycle after each pulse, so no two drives share an edge
	task automatic put(input hubctl_pkg::hubctl_rx_t v, output logic a);
		@(negedge clk);
		rx = v;
		#1;
		// an answer without its valid reads as unknown, so no check can pass on it
		a = ack_valid ? ack : 1'hx;
		@(negedge clk);
		rx = '0;
	endtask : put

	// start, restart or stop; a restart may be repeated at will
	task automatic cond(input logic [2:0] c);
		logic a;
		put({c, 11'h0}, a);
	endtask : cond

	task automatic addr(input logic [7:0] v, input logic rs, output logic a);
		put({1'h0, rs, 2'h1, 1'h0, v, 1'h0}, a);
	endtask : addr

	task automatic data(input logic [7:0] v, input logic pe, output logic a);
		put({5'h01, v, pe}, a);
	endtask : data

	// bounded wait; a byte that never comes reads as unknown
	task automatic take(output logic [7:0] b, output logic t);
		int n;
		n = 0;
		b = 'x;
		t = 1'hx;
		while (tx_valid !== 1'h1 && n < 64)
		begin
			@(negedge clk);
			n++;
		end
		if (tx_valid === 1'h1)
		begin
			b = tx_byte;
			t = tx_tbit;
			tx_taken = 1'h1;
			@(negedge clk);
			tx_taken = 1'h0;
		end
	endtask : take
endmodule : hubctl_host_model

// ---- bench/testbench.sv ----
`timescale 1ns/10ps
module testbench;
	logic                      clk, rst, tx_taken, relay_done, pec_en;
	logic                      ack, ack_valid, tx_tbit, tx_valid, relay_start;
	logic                      hid_translate_off, i3c_mode, int_enable;
	logic                      ccc_push_pull, device_control_cmd_strobe;
	logic [7:0]                relay_status, tx_byte, device_control_cmd_data;
	logic [31:0]               relay_data;
	logic [2:0]                hub_id_field;
	hubctl_pkg::hubctl_rx_t    rx;
	hubctl_pkg::hubctl_relay_t relay_req;
	int                        fail_count, compares, starts, strobes;

	hubctl_ctrl dut (.clk(clk), .rst(rst), .rx(rx), .tx_taken(tx_taken),
		.relay_status(relay_status), .relay_data(relay_data), .relay_done(relay_done),
		.pec_en(pec_en), .ack(ack), .ack_valid(ack_valid), .tx_byte(tx_byte),
		.tx_tbit(tx_tbit), .tx_valid(tx_valid), .relay_req(relay_req),
		.relay_start(relay_start), .hub_id_field(hub_id_field),
		.hid_translate_off(hid_translate_off), .i3c_mode(i3c_mode),
		.int_enable(int_enable), .ccc_push_pull(ccc_push_pull),
		.device_control_cmd_data(device_control_cmd_data), .device_control_cmd_strobe(device_control_cmd_strobe));

	hubctl_host_model host (.clk(clk), .ack(ack), .ack_valid(ack_valid), .tx_valid(tx_valid),
		.tx_byte(tx_byte), .tx_tbit(tx_tbit), .rx(rx), .tx_taken(tx_taken));

	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (relay_start === 1'h1)
			starts++;
		if (device_control_cmd_strobe === 1'h1)
			strobes++;
	end

	// ----
	// helpers
	// ----
	function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] x;
		x = c ^ d;
		for (int i = 0; i < 8; i++)
			x = x[7] ? ({x[6:0], 1'h0} ^ 8'h07) : {x[6:0], 1'h0};
		return x;
	endfunction : crc

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h want %h", $time, s, e);
		end
	endtask : check

	task automatic conclude();
		if (fail_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	// relayed read; check byte covers the acked read select onwards
	task automatic relay(input logic [7:0] s);
		logic       a, t;
		logic [7:0] b, p;
		logic [7:0] w [6] = '{8'h2d, 8'h04, 8'h00, 8'h03, 8'h01, 8'h44};
		logic [7:0] q [7] = '{8'h05, 8'h3c, 8'h12, 8'h34, 8'h56, 8'h78, 8'h00};
		int         n;
		n = starts;
		host.cond(3'h4);
		host.addr(s, 1'h0, a);
		check(a, 1);
		foreach (w[i])
			host.data(w[i], 1'h0, a);
		host.cond(3'h2);
		host.addr(s | 8'h01, 1'h1, a);
		check(a, 1);
		check(starts - n, 1);
		check(relay_req, {8'h2d, 8'h03, 8'h01, 8'h44});
		@(negedge clk);
		relay_status = 8'h3c;
		relay_data = 32'h12345678;
		relay_done = 1'h1;
		@(negedge clk);
		relay_done = 1'h0;
		p = crc(8'h00, s | 8'h01);
		for (int i = 0; i < 6; i++)
			p = crc(p, q[i]);
		q[6] = p;
		for (int i = 0; i < 7; i++)
		begin
			host.take(b, t);
			check(b, q[i]);
			check(t, i < 6);
		end
		host.cond(3'h1);
	endtask : relay

	// broadcast command, optional argument in g[7:0] when g[8] set
	task automatic ccc(input logic [7:0] c, input logic [8:0] g, output logic a);
		logic x;
		host.cond(3'h4);
		host.addr(8'hfc, 1'h0, x);
		check(ccc_push_pull, 1);
		host.data(c, 1'h0, a);
		if (g[8])
			host.data(g[7:0], 1'h0, x);
		host.cond(3'h1);
	endtask : ccc

	// ----
	// tests
	// ----
	initial
	begin
		#100us;
		fail_count++;
		conclude();
	end

	initial
	begin
		logic       a;
		logic [7:0] k [14] = '{8'h00, 8'h80, 8'h01, 8'h81, 8'h06, 8'h29, 8'h90,
			8'he0, 8'h61, 8'h62, 8'h07, 8'h2a, 8'h91, 8'hff};
		logic [7:0] p;
		logic [7:0] w [6] = '{8'h2d, 8'h04, 8'h00, 8'h03, 8'h01, 8'h44};
		int         n;
		rst = 1'h1;
		pec_en = 1'h0;
		relay_done = 1'h0;
		relay_status = 8'h00;
		relay_data = 32'h0;
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst = 1'h0;
		check({hub_id_field, i3c_mode, int_enable, tx_valid, relay_start}, 0);
		relay(8'hb0);
		// foreign select: its parity error must leave no trace
		host.cond(3'h4);
		host.addr(8'hc0, 1'h0, a);
		check(a, 0);
		host.data(8'h11, 1'h1, a);
		host.cond(3'h2);
		host.addr(8'hb0, 1'h1, a);
		check(a, 1);
		host.cond(3'h1);
		host.cond(3'h4);
		host.addr(8'hb0, 1'h0, a);
		host.data(8'h2d, 1'h1, a);
		repeat (3)
		begin
			host.cond(3'h2);
			host.addr(8'hb1, 1'h1, a);
			check(a, 0);
		end
		host.cond(3'h1);
		host.cond(3'h4);
		host.addr(8'hb0, 1'h0, a);
		check(a, 1);
		host.cond(3'h1);
		ccc(8'h00, 9'h101, a);
		host.cond(3'h4);
		check(int_enable, 0);
		host.cond(3'h1);
		ccc(8'h29, 9'h000, a);
		check(i3c_mode, 1);
		ccc(8'h00, 9'h101, a);
		check(int_enable, 0);
		host.cond(3'h4);
		check(int_enable, 1);
		host.cond(3'h1);
		ccc(8'h01, 9'h101, a);
		check(int_enable, 1);
		host.cond(3'h4);
		check(int_enable, 0);
		host.cond(3'h1);
		// event codes are only acked in fast-bus mode, so the sweep runs before the reset
		foreach (k[i])
		begin
			ccc(k[i], 9'h000, a);
			check(a, i < 10);
		end
		check(ccc_push_pull, 1);
		ccc(8'h06, 9'h000, a);
		check(i3c_mode, 0);
		check(ccc_push_pull, 0);
		ccc(8'h61, 9'h10a, a);
		check({hid_translate_off, hub_id_field}, 4'hd);
		relay(8'hba);
		n = strobes;
		ccc(8'h62, 9'h15a, a);
		check(device_control_cmd_data, 8'h5a);
		check(strobes - n, 1);
		// check byte on the write: a bad one makes the read restart fail
		pec_en = 1'h1;
		for (int j = 0; j < 2; j++)
		begin
			host.cond(3'h4);
			host.addr(8'hba, 1'h0, a);
			p = crc(8'h00, 8'hba);
			foreach (w[i])
			begin
				host.data(w[i], 1'h0, a);
				p = crc(p, w[i]);
			end
			host.data(j ? p : ~p, 1'h0, a);
			host.cond(3'h2);
			host.addr(8'hbb, 1'h1, a);
			check(a, j);
			host.cond(3'h1);
		end
		pec_en = 1'h0;
		conclude();
	end
endmodule : testbench

// ---- core/hubctl_crc8.sv ----
`timescale 1ns/10ps
`include "hubctl_defines.svh"

// one byte step of the packet error check, x^8+x^2+x+1
module hubctl_crc8 (
	input  wire logic [7:0] crc_in,
	input  wire logic [7:0] data,
	output logic      [7:0] crc_out
);
	always_comb
	begin
		logic [7:0] c;
		c = crc_in ^ data;
		for (int i = 0; i < 8; i++)
		begin
			if (c[7])
				c = {c[6:0], 1'h0} ^ `HUBCTL_CRC_POLY;
			else
				c = {c[6:0], 1'h0};
		end
		crc_out = c;
	end
endmodule : hubctl_crc8

// ---- core/hubctl_ctrl.sv ----
`timescale 1ns/10ps
`include "hubctl_defines.svh"

// Summary of operation
// RULE1: host writes relay select, command, count four, zero, channel, page, register.
// RULE2: after read restart return count, status, four data bytes msb first, check byte.
// RULE3: transition bit high on each returned byte, low on the check byte.
// RULE4: on chained restart after parity or check failure, nack the select code.
// RULE5: foreign select code: skip checks, ignore packet until stop or restart.
// RULE6: after an error every restart retry is nacked; otherwise it may be acked.
// RULE7: check sum includes only the acknowledged select code, not nacked retries.
// RULE8: restart alone or restart followed by broadcast address both count as restart.
// RULE9: nack any common command code outside the supported set.
// RULE10: support event enable/disable, get status and get capability codes.
// RULE11: host puts stop between common commands and private accesses.
// RULE12: host puts stop between direct and following broadcast command.
// RULE13: accept restart between like commands and between private accesses.
// RULE14: common commands always use fast timing regardless of legacy mode.
// RULE15: before address assignment ack may be held; then push-pull at low rate.
// RULE16: dynamic address reset command returns the device to legacy mode.
// RULE17: set-all-static command enters fast-bus mode.
// RULE18: set hub id updates id, parity handling and stops id translation.
// RULE19: device control applies configuration to hub and all devices behind.
// RULE20: event enable and disable honoured only in fast-bus mode.
// RULE21: enable sets, disable clears interrupt bit; effective from next start after stop.
module hubctl_ctrl (
	input  wire logic                      clk,
	input  wire logic                      rst,
	input  wire hubctl_pkg::hubctl_rx_t    rx,
	input  wire logic                      tx_taken,
	input  wire logic [7:0]                relay_status,
	input  wire logic [31:0]               relay_data,
	input  wire logic                      relay_done,
	input  wire logic                      pec_en,
	output logic                           ack,
	output logic                           ack_valid,
	output logic [7:0]                     tx_byte,
	output logic                           tx_tbit,
	output logic                           tx_valid,
	output hubctl_pkg::hubctl_relay_t      relay_req,
	output logic                           relay_start,
	output logic [2:0]                     hub_id_field,
	output logic                           hid_translate_off,
	output logic                           i3c_mode,
	output logic                           int_enable,
	output logic                           ccc_push_pull,
	output logic [7:0]                     device_control_cmd_data,
	output logic                           device_control_cmd_strobe
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {
		HUBCTL_IDLE, HUBCTL_IGNORE, HUBCTL_CCC, HUBCTL_CCC_ARG, HUBCTL_RELAY_WR, HUBCTL_RELAY_RD
	} hubctl_st_t;

	hubctl_st_t              st_reg;
	hubctl_pkg::hubctl_last_t last_reg;
	logic [7:0]              ccc_reg;
	logic [2:0]              idx_reg;
	logic                    err_reg;
	logic                    int_pend_reg;
	logic [7:0]              crc_reg;
	logic [7:0]              crc_step;
	logic                    stopped_reg;
	logic [7:0]              cnt_reg;
	logic                    sel_relay;
	logic                    sel_bcast;
	logic                    ccc_ok;
	logic                    ccc_bc;
	logic                    ack_now;

	hubctl_crc8 u_crc (
		.crc_in  (crc_reg),
		.data    (tx_valid ? tx_byte : rx.value),
		.crc_out (crc_step)
	);

	assign sel_relay = rx.value[7:4] == `HUBCTL_SEL_RELAY && rx.value[3:1] == hub_id_field;
	assign sel_bcast = rx.value[7:1] == `HUBCTL_SEL_BCAST;

	// ----------------------------------------
	// supported codes
	// ----------------------------------------
	always_comb
	begin
		ccc_ok = 1'b1;
		ccc_bc = 1'b1;
		unique case (rx.value) // [RULE10]
			`HUBCTL_CCC_EVENT_ENABLE_CMD_B, `HUBCTL_CCC_EVENT_DISABLE_CMD_B: ccc_ok = i3c_mode; // [RULE20]
			`HUBCTL_CCC_EVENT_ENABLE_CMD_D, `HUBCTL_CCC_EVENT_DISABLE_CMD_D:
			begin
				ccc_ok = i3c_mode;
				ccc_bc = 1'b0;
			end
			`HUBCTL_CCC_GETSTAT, `HUBCTL_CCC_GETCAP: ccc_bc = 1'b0;
			`HUBCTL_CCC_DYN_ADDR_RESET_CMD, `HUBCTL_CCC_STATIC_ADDR_ALL_CMD, `HUBCTL_CCC_SET_HUB_ID_CMD, `HUBCTL_CCC_DEVICE_CONTROL_CMD: ccc_ok = 1'b1;
			default: ccc_ok = 1'b0; // [RULE9]
		endcase
	end

	// address and command-code acknowledge decision, combinational handshake
	always_comb
	begin
		ack_now = 1'b0;
		if (rx.addr && !(rx.rstart && err_reg)) // [RULE4] [RULE6]
		begin
			// private select on a restart straight after a command is refused
			if (sel_relay)
				ack_now = !(rx.rstart && last_reg inside {hubctl_pkg::HUBCTL_LAST_CCC_B,
					hubctl_pkg::HUBCTL_LAST_CCC_D}); // [RULE11] [RULE13]
			else if (sel_bcast)
				ack_now = 1'b1;
		end
		else if (rx.data && st_reg == HUBCTL_CCC)
			ack_now = ccc_ok; // [RULE9]
	end
	assign ack       = ack_now;
	assign ack_valid = rx.addr || (rx.data && st_reg == HUBCTL_CCC);
	// common commands run push-pull fast timing whatever the mode
	assign ccc_push_pull = st_reg inside {HUBCTL_CCC, HUBCTL_CCC_ARG} || i3c_mode; // [RULE14] [RULE15]

	// ----------------------------------------
	// transaction sequencing
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_reg   <= HUBCTL_IDLE;
			last_reg <= hubctl_pkg::HUBCTL_LAST_NONE;
			idx_reg  <= 3'h0;
			ccc_reg  <= 8'h00;
		end
		else if (rx.stop)
		begin
			st_reg   <= HUBCTL_IDLE;
			last_reg <= hubctl_pkg::HUBCTL_LAST_NONE;
		end
		// the restart flag rides along with a restart address, so that byte is decoded
		else if ((rx.start || rx.rstart) && !rx.addr)
			st_reg <= HUBCTL_IDLE; // [RULE5]
		else if (rx.addr)
		begin
			idx_reg <= 3'h0;
			if (!ack_now)
				st_reg <= HUBCTL_IGNORE; // [RULE5]
			// bare restart or restart plus broadcast: a following restart just ends it
			else if (sel_bcast)
				st_reg <= HUBCTL_CCC; // [RULE8] [RULE13]
			else if (rx.value[0])
				st_reg <= HUBCTL_RELAY_RD;
			else
			begin
				st_reg   <= HUBCTL_RELAY_WR; // [RULE1]
				last_reg <= hubctl_pkg::HUBCTL_LAST_PRIV;
			end
		end
		else if (rx.data)
		begin
			unique case (st_reg)
				HUBCTL_CCC:
				begin
					ccc_reg  <= rx.value;
					st_reg   <= ccc_ok ? HUBCTL_CCC_ARG : HUBCTL_IGNORE;
					last_reg <= ccc_bc ? hubctl_pkg::HUBCTL_LAST_CCC_B : hubctl_pkg::HUBCTL_LAST_CCC_D;
				end
				HUBCTL_RELAY_WR: idx_reg <= idx_reg + 3'h1; // [RULE1]
				default: idx_reg <= idx_reg;
			endcase
		end
		else if (tx_taken)
		begin
			idx_reg <= idx_reg + 3'h1;
			if (idx_reg == `HUBCTL_RELAY_RD_LEN - 3'h1)
				st_reg <= HUBCTL_IGNORE;
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			stopped_reg <= 1'b1;
		else if (rx.stop)
			stopped_reg <= 1'b1;
		else if (rx.addr)
			stopped_reg <= 1'b0; // [RULE11] [RULE12]
	end

	// ----------------------------------------
	// error and check sum
	// ----------------------------------------
	// error sticks across restarts so retries keep failing until a stop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			err_reg <= 1'b0;
		else if (rx.stop)
			err_reg <= 1'b0;
		else if (rx.data && rx.par_err && st_reg != HUBCTL_IGNORE)
			err_reg <= 1'b1; // [RULE5] [RULE6]
		else if (rx.data && pec_en && st_reg == HUBCTL_RELAY_WR && idx_reg == `HUBCTL_RELAY_WR_LEN
			&& crc_step != 8'h00)
			err_reg <= 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			crc_reg <= `HUBCTL_CRC_INIT;
		else if ((rx.start || rx.rstart || rx.stop) && !rx.addr)
			crc_reg <= `HUBCTL_CRC_INIT;
		else if (rx.addr && ack_now && !sel_bcast)
			crc_reg <= crc_step; // [RULE7]
		else if (rx.data && st_reg != HUBCTL_IGNORE)
			crc_reg <= crc_step; // [RULE5]
		else if (tx_taken)
			crc_reg <= crc_step;
	end

	// ----------------------------------------
	// relay request and read return
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			relay_req   <= '0;
			relay_start <= 1'b0;
			cnt_reg     <= 8'h00;
		end
		else
		begin
			relay_start <= 1'b0;
			if (rx.data && st_reg == HUBCTL_RELAY_WR)
			begin
				unique case (idx_reg) // [RULE1]
					3'h0: relay_req.cmd     <= rx.value;
					3'h1: cnt_reg           <= rx.value;
					3'h3: relay_req.chan    <= rx.value;
					3'h4: relay_req.page    <= rx.value;
					3'h5:
					begin
						relay_req.reg_num <= rx.value;
						relay_start       <= cnt_reg == `HUBCTL_RELAY_COUNT;
					end
					default: cnt_reg <= cnt_reg;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tx_byte  <= 8'h00;
			tx_tbit  <= 1'b0;
			tx_valid <= 1'b0;
		end
		else if (st_reg != HUBCTL_RELAY_RD || rx.stop || rx.rstart)
			tx_valid <= 1'b0;
		else if (relay_done || tx_valid)
		begin
			tx_valid <= !(tx_taken && idx_reg == `HUBCTL_RELAY_RD_LEN - 3'h1);
			tx_tbit  <= 1'b1; // [RULE3]
			unique case (tx_taken ? idx_reg + 3'h1 : idx_reg) // [RULE2]
				3'h0: tx_byte <= `HUBCTL_RELAY_COUNT + 8'h01;
				3'h1: tx_byte <= relay_status;
				3'h2: tx_byte <= relay_data[31:24];
				3'h3: tx_byte <= relay_data[23:16];
				3'h4: tx_byte <= relay_data[15:8];
				3'h5: tx_byte <= relay_data[7:0];
				3'h6:
				begin
					tx_byte <= tx_taken ? crc_step : crc_reg;
					tx_tbit <= 1'b0; // [RULE3]
				end
				default: tx_byte <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// common command effects
	// ----------------------------------------
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			i3c_mode          <= 1'b0;
			hub_id_field      <= `HUBCTL_HID_RST;
			hid_translate_off <= 1'b0;
			int_pend_reg      <= 1'b0;
			device_control_cmd_data      <= 8'h00;
			device_control_cmd_strobe    <= 1'b0;
		end
		else
		begin
			device_control_cmd_strobe <= 1'b0;
			if (rx.data && st_reg == HUBCTL_CCC && ccc_ok)
			begin
				if (rx.value == `HUBCTL_CCC_DYN_ADDR_RESET_CMD)
					i3c_mode <= 1'b0; // [RULE16]
				if (rx.value == `HUBCTL_CCC_STATIC_ADDR_ALL_CMD)
					i3c_mode <= 1'b1; // [RULE17]
				if (rx.value == `HUBCTL_CCC_EVENT_ENABLE_CMD_B || rx.value == `HUBCTL_CCC_EVENT_ENABLE_CMD_D)
					int_pend_reg <= 1'b1; // [RULE21]
				if (rx.value == `HUBCTL_CCC_EVENT_DISABLE_CMD_B || rx.value == `HUBCTL_CCC_EVENT_DISABLE_CMD_D)
					int_pend_reg <= 1'b0; // [RULE21]
			end
			else if (rx.data && st_reg == HUBCTL_CCC_ARG && !rx.par_err)
			begin
				if (ccc_reg == `HUBCTL_CCC_SET_HUB_ID_CMD)
				begin
					hub_id_field      <= rx.value[3:1]; // [RULE18]
					hid_translate_off <= 1'b1;
				end
				if (ccc_reg == `HUBCTL_CCC_DEVICE_CONTROL_CMD)
				begin
					device_control_cmd_data   <= rx.value; // [RULE19]
					device_control_cmd_strobe <= 1'b1;
				end
			end
		end
	end

	// pending value only goes live at a start that follows a stop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			int_enable <= 1'b0;
		else if (rx.start && stopped_reg)
			int_enable <= int_pend_reg; // [RULE21]
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_err_nack;
		@(posedge clk) disable iff (rst) (rx.addr && rx.rstart && err_reg) |-> !ack; // [RULE4]
	endproperty
	a_err_nack: assert property (p_err_nack) else $error("restart acked after error");

	property p_unsup;
		@(posedge clk) disable iff (rst) (rx.data && st_reg == HUBCTL_CCC && !ccc_ok) |-> !ack; // [RULE9]
	endproperty
	a_unsup: assert property (p_unsup) else $error("unsupported code acked");

	property p_ignore;
		@(posedge clk) disable iff (rst) (st_reg == HUBCTL_IGNORE && rx.data && !rx.stop) |=> $stable(err_reg); // [RULE5]
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored byte changed error");

	property p_dyn_addr_reset_cmd;
		@(posedge clk) disable iff (rst)
			(rx.data && st_reg == HUBCTL_CCC && rx.value == `HUBCTL_CCC_DYN_ADDR_RESET_CMD) |=> !i3c_mode; // [RULE16]
	endproperty
	a_dyn_addr_reset_cmd: assert property (p_dyn_addr_reset_cmd) else $error("legacy mode not entered");

	property p_static_addr_all_cmd;
		@(posedge clk) disable iff (rst)
			(rx.data && st_reg == HUBCTL_CCC && rx.value == `HUBCTL_CCC_STATIC_ADDR_ALL_CMD) |=> i3c_mode; // [RULE17]
	endproperty
	a_static_addr_all_cmd: assert property (p_static_addr_all_cmd) else $error("fast mode not entered");

	property p_event_enable_cmd_legacy;
		@(posedge clk) disable iff (rst)
			(rx.data && st_reg == HUBCTL_CCC && !i3c_mode && rx.value == `HUBCTL_CCC_EVENT_ENABLE_CMD_B) |=> $stable(int_pend_reg); // [RULE20]
	endproperty
	a_event_enable_cmd_legacy: assert property (p_event_enable_cmd_legacy) else $error("enable honoured in legacy mode");

	property p_int_timing;
		@(posedge clk) disable iff (rst) !(rx.start && stopped_reg) |=> $stable(int_enable); // [RULE21]
	endproperty
	a_int_timing: assert property (p_int_timing) else $error("interrupt enable changed early");

	property p_last_t;
		@(posedge clk) disable iff (rst) (tx_valid && tx_byte == crc_reg && idx_reg == 3'h6) |-> !tx_tbit; // [RULE3]
	endproperty
	a_last_t: assert property (p_last_t) else $error("check byte transition bit high");

	property p_set_hub_id_cmd;
		@(posedge clk) disable iff (rst)
			(rx.data && st_reg == HUBCTL_CCC_ARG && ccc_reg == `HUBCTL_CCC_SET_HUB_ID_CMD && !rx.par_err)
			|=> hid_translate_off && hub_id_field == $past(rx.value[3:1]); // [RULE18]
	endproperty
	a_set_hub_id_cmd: assert property (p_set_hub_id_cmd) else $error("hub id not updated");

	property p_device_control_cmd;
		@(posedge clk) disable iff (rst)
			(rx.data && st_reg == HUBCTL_CCC_ARG && ccc_reg == `HUBCTL_CCC_DEVICE_CONTROL_CMD && !rx.par_err) |=> device_control_cmd_strobe; // [RULE19]
	endproperty
	a_device_control_cmd: assert property (p_device_control_cmd) else $error("device control not applied");

endmodule : hubctl_ctrl

// ---- core/hubctl_defines.svh ----
`ifndef HUBCTL_DEFINES_SVH
`define HUBCTL_DEFINES_SVH

// select codes (relay 4-bit prefix, broadcast 7-bit)
`define HUBCTL_SEL_RELAY     4'hb
`define HUBCTL_SEL_BCAST     7'h7e
// common command codes
`define HUBCTL_CCC_EVENT_ENABLE_CMD_B    8'h00
`define HUBCTL_CCC_EVENT_ENABLE_CMD_D    8'h80
`define HUBCTL_CCC_EVENT_DISABLE_CMD_B   8'h01
`define HUBCTL_CCC_EVENT_DISABLE_CMD_D   8'h81
`define HUBCTL_CCC_DYN_ADDR_RESET_CMD    8'h06
`define HUBCTL_CCC_STATIC_ADDR_ALL_CMD   8'h29
`define HUBCTL_CCC_GETSTAT   8'h90
`define HUBCTL_CCC_GETCAP    8'he0
`define HUBCTL_CCC_SET_HUB_ID_CMD    8'h61
`define HUBCTL_CCC_DEVICE_CONTROL_CMD   8'h62
// relay packet
`define HUBCTL_RELAY_COUNT   8'h04
`define HUBCTL_RELAY_RSV     8'h00
`define HUBCTL_RELAY_WR_LEN  3'h6
`define HUBCTL_RELAY_RD_LEN  3'h7
// event enable bit position in the interrupt config register
`define HUBCTL_INT_EN_BIT    4
// reset values and check polynomial
`define HUBCTL_HID_RST       3'h0
`define HUBCTL_CRC_INIT      8'h00
`define HUBCTL_CRC_POLY      8'h07

`endif

// ---- core/hubctl_pkg.sv ----
package hubctl_pkg;

	typedef enum logic [1:0] {
		HUBCTL_LAST_NONE,
		HUBCTL_LAST_PRIV,
		HUBCTL_LAST_CCC_B,
		HUBCTL_LAST_CCC_D
	} hubctl_last_t;

	// byte handed up from the bus shifter
	typedef struct packed {
		logic       start;
		logic       rstart;
		logic       stop;
		logic       addr;
		logic       data;
		logic [7:0] value;
		logic       par_err;
	} hubctl_rx_t;

	// relayed read request towards the driver behind the hub
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] chan;
		logic [7:0] page;
		logic [7:0] reg_num;
	} hubctl_relay_t;

endpackage : hubctl_pkg
